//--- afe_conv_model.sv
// Converter-side partner: one-cycle ready pulses, each carrying a code.
// Assumes pulse is called just after a rising clk_sys edge.
module afe_conv_model
  import afe_regs_pkg::*;
(
  // Clock.
  input  wire logic            clk_sys,
  // Converter outputs.
  output afe_conv_t [NCH-1:0]  conv_in
);
  timeunit 1ns;
  timeprecision 1ps;

  afe_conv_t conv_r [NCH];

  // ====================
  // Outside a pulse the code lines carry the inverted last code.
  // A stale capture then cannot pass for a good one.
  initial
  begin
    for (int i = 0; i < NCH; i++) conv_r[i] = '0;
  end

  always_comb
  begin
    for (int i = 0; i < NCH; i++) conv_in[i] = conv_r[i];
  end

  task automatic pulse(input int ch, input logic [RES_W-1:0] code);
    conv_r[ch] <= {code, 1'b1};
    @(posedge clk_sys);
    conv_r[ch] <= {~code, 1'b0};
  endtask
endmodule

//--- afe_data_phase_gain_regs.sv
// Result, comparator snapshot, phase delay and amplifier gain registers of a
// three-channel delta-sigma front end, reached over an APB slave port.
// Assumes converters on clk_sys give one-cycle ready pulses with their codes.
// Operation
// - Each result register holds its channel's newest 24-bit code, read-only.
// - Results read singly or as a linked sequence per the read loop setting.
// - A result read freezes the result registers for the transfer.
// - A conversion during a read is kept pending, then latched afterwards.
// - With merging on, all results update together on the last ready.
// - Offset and scale correction apply when their enables are set.
// - Results are presented as 16, 24 or 32 bits per the width setting.
// - Comparator snapshot refreshes once every modulator clock period.
// - Comparator snapshot resets to the zero-volt input pattern.
// - Snapshot bits 11-8 channel 2, 7-4 channel 1, 3-0 channel 0.
// - Any phase write restarts all active converters.
// - Phase bits 23-12 delay channel 2 after channel 1 in modulator periods.
// - Phase bits 11-0 delay channel 0 after channel 1 in modulator periods.
// - Three-bit gain code per channel; codes 0 to 5 give gains 1 to 32.
// - Gain codes 6 and 7 act as gain one at amp_gain_shift; amp_gain_code passes them through unchanged.
// - Gain register bits above 8 read as zero.
// - Merging gives one ready pulse for all channels, else one per cycle in which any channel is ready.
module afe_data_phase_gain_regs
  import afe_regs_pkg::*;
(
  // Clock and reset.
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  // APB slave.
  input  wire logic [ADDR_W-1:0]      paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Converter side.
  input  wire afe_conv_t [NCH-1:0]    conv_in,
  input  wire afe_cal_t  [NCH-1:0]    cal_in,
  input  wire logic [CMP_W-1:0]       comp_bits,
  input  wire logic [NCH-1:0]         chan_active,
  // Converter control.
  output logic                        mod_tick,
  output logic                        ready_pulse,
  output logic                        conv_restart,
  output logic      [NCH-1:0]         chan_start,
  output logic      [GAIN_BITS-1:0]   amp_gain_code,
  output logic      [GAIN_BITS-1:0]   amp_gain_shift
);

  // ==========================================================================
  // Helper functions.

  // Clamp a wide signed value into the 24-bit signed code range.
  function automatic logic [RES_W-1:0] sat24(input logic signed [48:0] v);
    if (v > 49'sh7fffff)
    begin
      return 24'h7fffff;
    end
    if (v < -49'sh800000)
    begin
      return 24'h800000;
    end
    return v[RES_W-1:0];
  endfunction

  // Offset is added first, then the unsigned 1.23 scale multiplies the sum.
  function automatic logic [RES_W-1:0] correct(input logic [RES_W-1:0] code,
                                               input afe_cal_t          cal,
                                               input logic              off_en,
                                               input logic              sc_en);
    logic [RES_W-1:0] y;
    y = code;
    if (off_en)
    begin
      y = sat24(49'(signed'(code)) + 49'(signed'(cal.offset)));
    end
    if (sc_en)
    begin
      y = sat24((49'(signed'(y)) * 49'(signed'({1'b0, cal.scale}))) >>> SCALE_FRAC);
    end
    return y;
  endfunction

  // Presentation format; the 16-bit form rounds and saturates at full scale.
  function automatic logic [31:0] fmt(input logic [RES_W-1:0] v, input logic [1:0] w);
    logic [24:0] r;
    logic [31:0] o;
    r = {v[23], v} + 25'h0000080;
    o = 32'h0;
    unique case (w)
      FMT_16:  o = (r[24] != r[23]) ? 32'h00007fff : {16'h0, r[23:8]};
      FMT_24:  o = {8'h0, v};
      FMT_32Z: o = {v, 8'h0};
      FMT_32S: o = {{8{v[23]}}, v};
    endcase
    return o;
  endfunction

  // Reserved gain codes fall back to a shift of zero, that is gain one.
  function automatic logic [GAIN_W-1:0] gain_shift(input logic [GAIN_W-1:0] c);
    return (c > GAIN_CODE_MAX) ? 3'h0 : c;
  endfunction

  // Byte-lane merge of a write into the old register contents.
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0]  strb);
    logic [31:0] o;
    o = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        o[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return o;
  endfunction

  function automatic logic is_result(input logic [5:0] i);
    return (i <= IDX_RES2) || (i == IDX_STREAM);
  endfunction

  function automatic logic is_mapped(input logic [5:0] i);
    return is_result(i) || (i == IDX_CMP) || (i == IDX_PHASE) || (i == IDX_GAIN)
           || (i == IDX_CTRL) || (i == IDX_STAT);
  endfunction

  // ==========================================================================
  // State.
  logic [RES_W-1:0]     result_r [NCH];
  logic [RES_W-1:0]     newest_r [NCH];
  logic [RES_W-1:0]     cur      [NCH];
  logic [NCH-1:0]       pend_r;
  logic [NCH-1:0]       seen_r;
  logic [NCH-1:0]       rdy;
  logic [NCH-1:0]       commit;
  logic                 all_seen;
  logic [1:0]           ptr_r;
  logic [CMP_W-1:0]     cmp_r;
  logic [2*PH_W-1:0]    phase_r;
  logic [GAIN_BITS-1:0] gain_r;
  afe_ctrl_t            ctrl_r;
  logic [DIV_W-1:0]     div_r;
  logic                 seq_run_r;
  logic [PH_W-1:0]      seq_cnt_r;
  logic [PH_W-1:0]      cnt_nxt;
  logic [PH_W-1:0]      dly_a;
  logic [PH_W-1:0]      dly_b;
  logic [PH_W-1:0]      dly_max;
  logic [NCH-1:0]       start_nxt;
  logic [31:0]          rd_val;
  logic [31:0]          wr_val;
  logic [5:0]           idx;
  logic                 setup;
  logic                 wr_acc;
  logic                 rd_acc;
  logic                 freeze;
  logic                 phase_wr;

  // ==========================================================================
  // APB decode: one setup cycle, one access cycle, never stretched.
  assign idx      = paddr[7:2];
  assign setup    = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite & is_mapped(idx);
  assign rd_acc   = psel & penable & ~pwrite;
  assign pready   = psel & penable;
  assign pslverr  = psel & penable & ~is_mapped(idx);
  assign freeze   = psel & ~pwrite & is_result(idx);
  assign phase_wr = wr_acc & (idx == IDX_PHASE);

  // Read data is sampled at the setup edge so prdata comes from a flip-flop.
  always_comb
  begin
    rd_val = 32'h0;
    if (idx <= IDX_RES2)
    begin
      rd_val = fmt(result_r[idx[1:0]], ctrl_r.width);
    end
    else if (idx == IDX_STREAM)
    begin
      rd_val = fmt(result_r[ptr_r], ctrl_r.width);
    end
    else if (idx == IDX_CMP)
    begin
      rd_val = {20'h0, cmp_r};
    end
    else if (idx == IDX_PHASE)
    begin
      rd_val = {8'h0, phase_r};
    end
    else if (idx == IDX_GAIN)
    begin
      rd_val = {23'h0, gain_r};
    end
    else if (idx == IDX_CTRL)
    begin
      rd_val[CTRL_MERGE_BIT]               = ctrl_r.merge;
      rd_val[CTRL_OFF_BIT]                 = ctrl_r.off_en;
      rd_val[CTRL_SCALE_BIT]               = ctrl_r.scale_en;
      rd_val[CTRL_WIDTH_LSB +: 2]          = ctrl_r.width;
      rd_val[CTRL_LOOP_LSB +: 2]           = ctrl_r.loop;
    end
    else if (idx == IDX_STAT)
    begin
      rd_val[NCH-1:0]                      = seen_r;
      rd_val[STAT_PEND_LSB +: NCH]         = pend_r;
      rd_val[STAT_RUN_BIT]                 = seq_run_r;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      prdata <= 32'h0;
    end
    else if (setup && !pwrite)
    begin
      prdata <= rd_val;
    end
  end

  // Writes land at the access edge; result indices have no write path.
  assign wr_val = lane_merge(rd_val, pwdata, pstrb);

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      phase_r <= 24'h0;
      gain_r  <= 9'h0;
      ctrl_r  <= '{loop: CTRL_LOOP_RST, width: CTRL_WIDTH_RST, default: 1'b0};
    end
    else if (wr_acc)
    begin
      unique case (idx)
        IDX_PHASE: phase_r <= wr_val[2*PH_W-1:0];
        IDX_GAIN:  gain_r  <= wr_val[GAIN_BITS-1:0];
        IDX_CTRL:  ctrl_r  <= '{loop:     wr_val[CTRL_LOOP_LSB +: 2],
                                width:    wr_val[CTRL_WIDTH_LSB +: 2],
                                scale_en: wr_val[CTRL_SCALE_BIT],
                                off_en:   wr_val[CTRL_OFF_BIT],
                                merge:    wr_val[CTRL_MERGE_BIT]};
        default:   ;
      endcase
    end
  end

  // ==========================================================================
  // Conversion capture. The corrected code is computed once, at capture.
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      rdy[c] = conv_in[c].ready;
      cur[c] = rdy[c] ? correct(conv_in[c].code, cal_in[c], ctrl_r.off_en, ctrl_r.scale_en)
                      : newest_r[c];
    end
    all_seen = (&(seen_r | rdy)) & (|rdy);
    commit   = ctrl_r.merge ? {NCH{all_seen}} : rdy;
  end

  // Newest corrected code per channel, kept even while results are frozen.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        newest_r[c] <= 24'h0;
      end
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (rdy[c])
        begin
          newest_r[c] <= cur[c];
        end
      end
    end
  end

  // Channels already ready since the last merged update; the lagging one ends it.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || !ctrl_r.merge || all_seen)
    begin
      seen_r <= 3'h0;
    end
    else
    begin
      seen_r <= seen_r | rdy;
    end
  end

  // A commit that meets a read is parked and applied once the read ends, so the
  // word on the bus never changes yet nothing newer is lost.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      pend_r <= 3'h0;
      for (int c = 0; c < NCH; c++)
      begin
        result_r[c] <= 24'h0;
      end
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (freeze)
        begin
          pend_r[c] <= pend_r[c] | commit[c];
        end
        else if (commit[c] || pend_r[c])
        begin
          result_r[c] <= cur[c];
          pend_r[c]   <= 1'b0;
        end
      end
    end
  end

  // One pulse per cycle with any channel ready, or a single pulse on the lagging channel when merged.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ready_pulse <= 1'b0;
    end
    else
    begin
      ready_pulse <= ctrl_r.merge ? all_seen : |rdy;
    end
  end

  // Linked read pointer: a direct read picks the start, stream reads walk on.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ptr_r <= 2'h0;
    end
    else if (rd_acc && (idx <= IDX_RES2 || idx == IDX_STREAM))
    begin
      if (ctrl_r.loop == LOOP_SINGLE)
      begin
        ptr_r <= (idx == IDX_STREAM) ? ptr_r : idx[1:0];
      end
      else
      begin
        ptr_r <= (((idx == IDX_STREAM) ? ptr_r : idx[1:0]) == 2'h2) ? 2'h0
               : ((idx == IDX_STREAM) ? ptr_r : idx[1:0]) + 2'h1;
      end
    end
  end

  // ==========================================================================
  // Modulator clock enable, one cycle per modulator period.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      div_r    <= 6'h0;
      mod_tick <= 1'b0;
    end
    else
    begin
      div_r    <= (div_r == DIV_W'(MOD_DIV - 1)) ? 6'h0 : div_r + 6'h1;
      mod_tick <= (div_r == DIV_W'(MOD_DIV - 1));
    end
  end

  // Comparator snapshot; a host write only lasts until the next refresh.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      cmp_r <= CMP_RST;
    end
    else if (mod_tick)
    begin
      cmp_r <= comp_bits;
    end
    else if (wr_acc && idx == IDX_CMP)
    begin
      cmp_r <= wr_val[CMP_W-1:0];
    end
  end

  // ==========================================================================
  // Restart sequencer: channel 1 starts with the restart, the others after
  // their delay in modulator periods.
  assign dly_a   = phase_r[PH_A_LSB +: PH_W];
  assign dly_b   = phase_r[PH_B_LSB +: PH_W];
  assign dly_max = (dly_a > dly_b) ? dly_a : dly_b;
  assign cnt_nxt = seq_cnt_r + 12'h001;

  always_comb
  begin
    start_nxt    = 3'h0;
    start_nxt[1] = conv_restart;
    start_nxt[0] = (conv_restart && dly_a == 12'h0)
                 || (seq_run_r && mod_tick && cnt_nxt == dly_a);
    start_nxt[2] = (conv_restart && dly_b == 12'h0)
                 || (seq_run_r && mod_tick && cnt_nxt == dly_b);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      conv_restart <= 1'b0;
      chan_start   <= 3'h0;
      seq_run_r    <= 1'b0;
      seq_cnt_r    <= 12'h0;
    end
    else
    begin
      conv_restart <= phase_wr;
      chan_start   <= start_nxt & chan_active;
      if (conv_restart)
      begin
        seq_run_r <= (dly_max != 12'h0);
        seq_cnt_r <= 12'h0;
      end
      else if (seq_run_r && mod_tick)
      begin
        seq_cnt_r <= cnt_nxt;
        seq_run_r <= (cnt_nxt < dly_max);
      end
    end
  end

  // ==========================================================================
  // Amplifier gain outputs.
  assign amp_gain_code = gain_r;

  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      amp_gain_shift[GAIN_W*c +: GAIN_W] = gain_shift(gain_r[GAIN_W*c +: GAIN_W]);
    end
  end

  // ==========================================================================
  // Assertions.
  a_cmp_refresh: assert property (@(posedge clk_sys) disable iff (!rstn)
    mod_tick |=> (cmp_r == $past(comp_bits)))
    else $error("snapshot not refreshed on modulator tick");

  a_cmp_upper: assert property (@(posedge clk_sys) disable iff (!rstn)
    (setup && !pwrite && idx == IDX_CMP) |=> (prdata[31:12] == 20'h0))
    else $error("snapshot upper bits not zero");

  a_res_frozen: assert property (@(posedge clk_sys) disable iff (!rstn)
    freeze |=> $stable(result_r[0]) && $stable(result_r[1]) && $stable(result_r[2]))
    else $error("result changed during read");

  a_pend_kept: assert property (@(posedge clk_sys) disable iff (!rstn)
    (freeze && rdy[1] && !ctrl_r.merge) |=> pend_r[1])
    else $error("conversion during read lost");

  // Once the read has ended, the parked code must land and the flag must drop.
  a_pend_apply: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pend_r[1] && !freeze && !rdy[1]) |=> (!pend_r[1] && (result_r[1] == newest_r[1])))
    else $error("parked conversion not applied");

  a_merge_single: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ctrl_r.merge && rdy == 3'h1 && seen_r == 3'h0) |=> !ready_pulse)
    else $error("merged mode pulsed before lagging channel");

  a_merge_update: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ctrl_r.merge && !rdy[0] && !freeze && !pend_r[0] && !all_seen) |=> $stable(result_r[0]))
    else $error("merged result updated early");

  a_restart_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
    (phase_wr && !$past(phase_wr)) |=> conv_restart ##1 (chan_start[1] == chan_active[1]))
    else $error("phase write did not restart");

  a_phase_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    (conv_restart && dly_a == 12'h0 && chan_active[0]) |=> chan_start[0])
    else $error("channel 0 start missing at zero delay");

  a_gain_resv: assert property (@(posedge clk_sys) disable iff (!rstn)
    (gain_r[8:6] > GAIN_CODE_MAX) |-> (amp_gain_shift[8:6] == 3'h0))
    else $error("reserved gain code not unity");

  a_gain_upper: assert property (@(posedge clk_sys) disable iff (!rstn)
    (setup && !pwrite && idx == IDX_GAIN) |=> (prdata[31:9] == 23'h0))
    else $error("gain upper bits not zero");

endmodule

//--- afe_data_phase_gain_regs_tb.sv
// Self-checking bench for the result, snapshot, phase and gain registers.
// Assumes the converter partner model and an APB slave with no wait states.
module afe_data_phase_gain_regs_tb
  import afe_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk_sys = 1'b0;
  logic                  rstn = 1'b0;
  logic [ADDR_W-1:0]     paddr = '0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [31:0]           pwdata = '0;
  logic [3:0]            pstrb = 4'hf;
  logic [31:0]           prdata, rd;
  logic                  pready, pslverr, er;
  afe_conv_t [NCH-1:0]   conv_in;
  afe_cal_t  [NCH-1:0]   cal_in = {NCH{24'h000010, 24'h800000}};
  logic [CMP_W-1:0]      comp_bits = 12'h5a5;
  logic [NCH-1:0]        chan_active = 3'h7;
  logic                  mod_tick, ready_pulse, conv_restart;
  logic [NCH-1:0]        chan_start;
  logic [GAIN_BITS-1:0]  amp_gain_code, amp_gain_shift;
  logic [2:0]            g, s;
  logic [23:0]           exp_res [NCH];
  logic [31:0]           fmt_exp [4] = '{32'h8765, 32'h876543, 32'h87654300, 32'hff876543};
  int                    err_count = 0, samples_checked = 0, rp_cnt = 0;
  int                    rs, tk, t0, t1, t2;

  // ====================
  // Clock, pulse counter and a watchdog against hangs.
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (ready_pulse === 1'b1) rp_cnt++;
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    stop_test();
  end

  afe_data_phase_gain_regs DUT (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_in(conv_in), .cal_in(cal_in),
    .comp_bits(comp_bits), .chan_active(chan_active), .mod_tick(mod_tick),
    .ready_pulse(ready_pulse), .conv_restart(conv_restart), .chan_start(chan_start),
    .amp_gain_code(amp_gain_code), .amp_gain_shift(amp_gain_shift));
  afe_conv_model u_conv (.clk_sys(clk_sys), .conv_in(conv_in));

  // ====================
  // Access tasks; every APB transfer begins one edge after the call.
  task automatic stop_test();
    $display("checked=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      err_count++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk(rd, want);
  endtask

  task automatic fire(input int ch, input logic [23:0] c);
    u_conv.pulse(ch, c);
    exp_res[ch] = c;
  endtask

  // ====================
  // Main sequence. The host never writes the snapshot register.
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    rd_chk(8'h20, 32'h333);
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h2c, 32'h0);
    repeat (110) @(posedge clk_sys);
    rd_chk(8'h20, 32'h5a5);
    apb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, er}, 32'h1);
    for (int c = 0; c < 8; c++)
    begin
      g = 3'(c);
      s = (c <= 5) ? g : 3'h0;
      apb(1'b1, 8'h2c, {8'hff, 15'h7fff, g, g, g});
      rd_chk(8'h2c, {23'h0, g, g, g});
      chk({23'h0, amp_gain_shift}, {23'h0, s, s, s});
      chk({23'h0, amp_gain_code}, {23'h0, g, g, g});
    end
    // Restart, then count modulator ticks up to each channel start.
    apb(1'b1, 8'h28, 32'h00002001);
    rs = 0;
    tk = 0;
    t0 = -1;
    t1 = -1;
    t2 = -1;
    repeat (200)
    begin
      @(posedge clk_sys);
      if (rs > 0 && mod_tick === 1'b1) tk++;
      if (conv_restart === 1'b1) rs++;
      if (chan_start[0] === 1'b1) t0 = tk;
      if (chan_start[1] === 1'b1) t1 = tk;
      if (chan_start[2] === 1'b1) t2 = tk;
    end
    chk(rs, 1);
    chk(t1, 0);
    chk(t0, 1);
    chk(t2, 2);
    rd_chk(8'h28, 32'h2001);
    // Zero delays start every active channel at once; inactive channel 1 stays idle.
    chan_active <= 3'h5;
    apb(1'b1, 8'h28, 32'h0);
    t0 = 0;
    t1 = 0;
    repeat (4)
    begin
      @(posedge clk_sys);
      t0 += (chan_start == 3'h5);
      t1 += (chan_start[1] !== 1'b0);
    end
    chk(t0, 1);
    chk(t1, 0);
    rp_cnt = 0;
    for (int c = 0; c < 3; c++)
    begin
      fire(c, 24'(24'h111111 * (c + 1)));
      rd_chk(8'(c * 4), {8'h0, exp_res[c]});
    end
    chk(rp_cnt, 3);
    apb(1'b1, 8'h00, 32'habcdef);
    rd_chk(8'h00, {8'h0, exp_res[0]});
    rd_chk(8'h88, {8'h0, exp_res[1]});
    rd_chk(8'h88, {8'h0, exp_res[2]});
    rd_chk(8'h88, {8'h0, exp_res[0]});
    // Single-address loop: the stream port keeps showing the last direct pick.
    apb(1'b1, 8'h80, 32'h010);
    rd_chk(8'h08, {8'h0, exp_res[2]});
    rd_chk(8'h88, {8'h0, exp_res[2]});
    rd_chk(8'h88, {8'h0, exp_res[2]});
    // A conversion lands in the setup cycle of a result read.
    fork
      rd_chk(8'h04, {8'h0, exp_res[1]});
      begin
        @(posedge clk_sys);
        u_conv.pulse(1, 24'h0a0b0c);
      end
    join
    rd_chk(8'h04, 32'h0a0b0c);
    // Merged mode: nothing moves until the last channel reports.
    apb(1'b1, 8'h80, 32'h211);
    rp_cnt = 0;
    u_conv.pulse(0, 24'h000aaa);
    u_conv.pulse(1, 24'h000bbb);
    rd_chk(8'h00, {8'h0, exp_res[0]});
    u_conv.pulse(2, 24'h000ccc);
    repeat (2) @(posedge clk_sys);
    chk(rp_cnt, 1);
    rd_chk(8'h00, 32'haaa);
    rd_chk(8'h04, 32'hbbb);
    rd_chk(8'h08, 32'hccc);
    for (int f = 0; f < 4; f++)
    begin
      apb(1'b1, 8'h80, 32'h200 | (f << 4));
      fire(0, 24'h876543);
      rd_chk(8'h00, fmt_exp[f]);
    end
    apb(1'b1, 8'h80, 32'h212);
    fire(0, 24'h000100);
    rd_chk(8'h00, 32'h110);
    cal_in[0].scale <= 24'h400000;
    apb(1'b1, 8'h80, 32'h216);
    fire(0, 24'h000100);
    rd_chk(8'h00, 32'h88);
    stop_test();
  end
endmodule

//--- afe_regs_pkg.sv
// Constants, field layouts and carrier types for the front-end register slice.
// Assumes a 50 MHz system clock and an APB master with 32-bit data.
package afe_regs_pkg;

  // ==========================================================================
  // Bus geometry: byte address is four times the register index.
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned RES_W      = 24;
  localparam int unsigned NCH        = 3;
  localparam logic [5:0]  IDX_RES0   = 6'h00;
  localparam logic [5:0]  IDX_RES2   = 6'h02;
  localparam logic [5:0]  IDX_CMP    = 6'h08;
  localparam logic [5:0]  IDX_PHASE  = 6'h0a;
  localparam logic [5:0]  IDX_GAIN   = 6'h0b;
  localparam logic [5:0]  IDX_CTRL   = 6'h20;
  localparam logic [5:0]  IDX_STAT   = 6'h21;
  localparam logic [5:0]  IDX_STREAM = 6'h22;

  // ==========================================================================
  // Field layouts and reset values.
  localparam int unsigned CMP_W          = 12;
  localparam logic [11:0] CMP_RST        = 12'h333;
  localparam int unsigned PH_W           = 12;
  localparam int unsigned PH_A_LSB       = 0;
  localparam int unsigned PH_B_LSB       = 12;
  localparam int unsigned GAIN_W         = 3;
  localparam int unsigned GAIN_BITS      = 9;
  localparam logic [2:0]  GAIN_CODE_MAX  = 3'h5;
  localparam int unsigned CTRL_MERGE_BIT = 0;
  localparam int unsigned CTRL_OFF_BIT   = 1;
  localparam int unsigned CTRL_SCALE_BIT = 2;
  localparam int unsigned CTRL_WIDTH_LSB = 4;
  localparam int unsigned CTRL_LOOP_LSB  = 8;
  localparam logic [1:0]  CTRL_WIDTH_RST = 2'h1;
  localparam logic [1:0]  CTRL_LOOP_RST  = 2'h2;
  localparam int unsigned STAT_PEND_LSB  = 4;
  localparam int unsigned STAT_RUN_BIT   = 8;
  localparam logic [1:0]  FMT_16         = 2'h0;
  localparam logic [1:0]  FMT_24         = 2'h1;
  localparam logic [1:0]  FMT_32Z        = 2'h2;
  localparam logic [1:0]  FMT_32S        = 2'h3;
  localparam logic [1:0]  LOOP_SINGLE    = 2'h0;
  localparam int unsigned SCALE_FRAC     = 23;

  // ==========================================================================
  // Timing: modulator clock period against the system clock period.
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned MODCLK_PERIOD_NS = 1000;
  localparam int unsigned MOD_DIV          = MODCLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_W            = 6;

  // ==========================================================================
  // Carriers.
  typedef struct packed {
    logic [RES_W-1:0] code;
    logic             ready;
  } afe_conv_t;

  typedef struct packed {
    logic [RES_W-1:0] offset;
    logic [RES_W-1:0] scale;
  } afe_cal_t;

  typedef struct packed {
    logic [1:0] loop;
    logic [1:0] width;
    logic       scale_en;
    logic       off_en;
    logic       merge;
  } afe_ctrl_t;

endpackage
